/* core/drac_map.svh */
// drac: strap decode constants, refresh timing counts and reset values
`ifndef DRAC_MAP_SVH
`define DRAC_MAP_SVH

`define DRAC_DIV_31         7'h1F
`define DRAC_DIV_46         7'h2E
`define DRAC_DIV_61         7'h3D
`define DRAC_DIV_76         7'h4C
`define DRAC_DIV_91         7'h5B
`define DRAC_REF_LEN_SHORT  3'h3
`define DRAC_REF_LEN_LONG   3'h4
`define DRAC_ROW_CNT_RESET  8'hFF
`define DRAC_ACC_LEN        3'h2

`endif

/* core/drac_pkg.sv */
// drac: shared types for the dram refresh and address controller
`default_nettype none
package drac_pkg;

    typedef enum logic [3:0] {
        DRAC_IDLE    = 4'b0001,
        DRAC_ACCESS  = 4'b0010,
        DRAC_REFRESH = 4'b0100,
        DRAC_HOLD    = 4'b1000
    } drac_state_type;

    typedef struct packed {
        logic       wait_strap;
        logic       rate_select_hi;
        logic       rate_select_lo;
    } drac_strap_type;

    typedef struct packed {
        logic [7:0] mem_addr_out;
        logic       mem_addr_oe_n;
        logic       row_strobe_bank0;
        logic       row_strobe_bank1;
        logic       col_strobe;
        logic       strobe_oe_n;
    } drac_mem_type;

endpackage : drac_pkg
`default_nettype wire

/* core/drac_ctrl.sv */
// drac: dram address multiplexer, arbiter and refresh controller
// What this block does
// - wait strap high adds one wait state
// - strap low rates: 31, 46, 61 clocks
// - strap high rates: 46, 61, 76, 91 clocks
// - refresh lasts three or four clocks
// - all straps low holds timer in reset
// - any refresh request restarts the rate counter
// - latch strobe high passes row address through
// - latches hold values after strobe falls
// - row counter decrements after each refresh
// - wait strap rising loads row counter 255
// - mux drives row, column or refresh address
// - arbiter handles access and refresh cycles
// - access blocked by refresh runs afterwards
// - strobe fall captures chip and bank select
// - bank select picks row strobe; refresh both
// - refresh request line held low until underway
// - access control drives column; both low floats
`include "drac_map.svh"
`default_nettype none
module drac_ctrl (
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    input  wire drac_pkg::drac_strap_type straps,
    input  wire logic                     addr_latch_strobe,
    input  wire logic                     chip_select_n,
    input  wire logic                     bank_select_in,
    input  wire logic [7:0]               row_addr_in,
    input  wire logic [7:0]               col_addr_in,
    input  wire logic                     read_access_ctl_n,
    input  wire logic                     write_access_ctl_n,
    input  wire logic                     refresh_req_in,
    output logic                          refresh_req_out,
    output logic                          refresh_req_oe_n,
    output drac_pkg::drac_mem_type        mem,
    output logic                          ready
);
    import drac_pkg::*;

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    // strap and control pin inputs are async to sys_clk; three stages, stage 2 == 3
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
    logic [NSYNC-1:0] clean_q, clean_d;
    // row bus delayed four clocks to line up with the synchronised strobe
    logic [7:0]       rp1_q, rp2_q, rp3_q, rp4_q;
    logic [7:0]       rp1_d, rp2_d, rp3_d, rp4_d;

    assign pin_raw = {straps.wait_strap, straps.rate_select_hi,
                      straps.rate_select_lo, addr_latch_strobe,
                      chip_select_n, bank_select_in, read_access_ctl_n,
                      write_access_ctl_n, refresh_req_in, 2'b00};

    always_comb begin
        s1_d = pin_raw;
        s2_d = s1_q;
        s3_d = s2_q;
        clean_d = clean_q;
        rp1_d = row_addr_in;
        rp2_d = rp1_q;
        rp3_d = rp2_q;
        rp4_d = rp3_q;
        for (int i = 0; i < NSYNC; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                clean_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            // idle pin levels, so no false edge follows reset
            s1_q    <= 11'h05C;
            s2_q    <= 11'h05C;
            s3_q    <= 11'h05C;
            clean_q <= 11'h05C;
            rp1_q   <= 8'h00;
            rp2_q   <= 8'h00;
            rp3_q   <= 8'h00;
            rp4_q   <= 8'h00;
        end else begin
            s1_q    <= s1_d;
            s2_q    <= s2_d;
            s3_q    <= s3_d;
            clean_q <= clean_d;
            rp1_q   <= rp1_d;
            rp2_q   <= rp2_d;
            rp3_q   <= rp3_d;
            rp4_q   <= rp4_d;
        end
    end

    logic wst, fs1, fs0, ale, cs_n, bsel, acr_n, acw_n, rreq;
    assign {wst, fs1, fs0, ale, cs_n, bsel, acr_n, acw_n, rreq} =
        clean_q[NSYNC-1:2];

    // ---------------------------------------------------------------
    // strap decode
    // ---------------------------------------------------------------
    function automatic logic [6:0] rate_div(input logic [2:0] s);
        case (s)
            3'b001:  rate_div = `DRAC_DIV_31;
            3'b010:  rate_div = `DRAC_DIV_46;
            3'b011:  rate_div = `DRAC_DIV_61;
            3'b100:  rate_div = `DRAC_DIV_46;
            3'b101:  rate_div = `DRAC_DIV_61;
            3'b110:  rate_div = `DRAC_DIV_76;
            3'b111:  rate_div = `DRAC_DIV_91;
            default: rate_div = 7'h00;
        endcase
    endfunction : rate_div

    logic [2:0] strap_code;
    logic       timer_off;
    logic [6:0] div_now;
    logic [2:0] ref_len;
    assign strap_code = {wst, fs1, fs0};
    assign timer_off  = (strap_code == 3'b000);
    assign div_now    = rate_div(strap_code);
    assign ref_len    = (div_now == `DRAC_DIV_31 || div_now == `DRAC_DIV_46)
                        ? `DRAC_REF_LEN_SHORT : `DRAC_REF_LEN_LONG;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    drac_state_type state_q, state_d;
    logic [6:0] rate_q, rate_d;
    logic [7:0] row_cnt_q, row_cnt_d;
    logic [2:0] phase_q, phase_d;
    logic       pend_ref_q, pend_ref_d;
    logic       pend_acc_q, pend_acc_d;
    logic       ale_q, ale_d, rreq_q, rreq_d, wst_q, wst_d;
    logic [7:0] row_lat_q, row_lat_d;
    logic       cs_lat_q, cs_lat_d, bank_lat_q, bank_lat_d;
    logic       drive_req_q, drive_req_d;
    logic       ref_shown_q, ref_shown_d;
    // own pull-down comes back through the synchroniser; mask that echo
    logic [5:0] echo_q, echo_d;

    logic ale_fall, ext_req, int_req, acc_on, acc_float;
    assign ale_fall  = ale_q & ~ale;
    assign ext_req   = rreq_q & ~rreq & ~drive_req_q & ~(|echo_q);
    assign int_req   = !timer_off && (rate_q == 7'd1);
    assign acc_on    = ~acr_n | ~acw_n;
    assign acc_float = ~acr_n & ~acw_n;

    always_comb begin
        state_d     = state_q;
        rate_d      = rate_q;
        row_cnt_d   = row_cnt_q;
        phase_d     = phase_q;
        pend_ref_d  = pend_ref_q;
        pend_acc_d  = pend_acc_q;
        ale_d       = ale;
        rreq_d      = rreq;
        wst_d       = wst;
        row_lat_d   = row_lat_q;
        cs_lat_d    = cs_lat_q;
        bank_lat_d  = bank_lat_q;
        drive_req_d = drive_req_q;
        ref_shown_d = 1'b0;
        echo_d      = {echo_q[4:0], drive_req_q & ~ref_shown_q};

        if (ale) begin
            row_lat_d = rp4_q;
        end
        if (ale_fall) begin
            cs_lat_d   = cs_n;
            bank_lat_d = bsel;
            if (!cs_n) begin
                pend_acc_d = 1'b1;
            end
        end
        if (ale & ~ale_q) begin
            cs_lat_d = 1'b1;
        end

        if (timer_off) begin
            rate_d = 7'h00;
        end else if (ext_req || int_req || rate_q == 7'h00) begin
            rate_d = div_now;
        end else begin
            rate_d = rate_q - 7'd1;
        end
        if (ext_req || int_req) begin
            pend_ref_d = 1'b1;
        end
        if (int_req) begin
            drive_req_d = 1'b1;
        end

        if (wst & ~wst_q) begin
            row_cnt_d = `DRAC_ROW_CNT_RESET;
        end

        case (state_q)
            DRAC_IDLE: begin
                phase_d = 3'd0;
                if (pend_ref_q) begin
                    state_d = DRAC_REFRESH;
                end else if (pend_acc_q) begin
                    state_d = DRAC_ACCESS;
                    pend_acc_d = 1'b0;
                end
            end
            DRAC_REFRESH: begin
                ref_shown_d = 1'b1;
                drive_req_d = 1'b0;
                pend_ref_d  = ext_req | int_req;
                phase_d     = phase_q + 3'd1;
                if (phase_q + 3'd1 >= ref_len) begin
                    state_d   = DRAC_IDLE;
                    row_cnt_d = row_cnt_q - 8'd1;
                    if (wst & ~wst_q) begin
                        row_cnt_d = `DRAC_ROW_CNT_RESET;
                    end
                end
            end
            DRAC_ACCESS: begin
                if (phase_q < (wst ? `DRAC_ACC_LEN : 3'd1)) begin
                    phase_d = phase_q + 3'd1;
                end
                if (ale & ~ale_q) begin
                    state_d = DRAC_HOLD;
                end
            end
            DRAC_HOLD: begin
                if (!acc_on) begin
                    state_d = DRAC_IDLE;
                end
            end
            default: state_d = DRAC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= DRAC_IDLE;
            rate_q      <= 7'h00;
            row_cnt_q   <= `DRAC_ROW_CNT_RESET;
            phase_q     <= 3'd0;
            pend_ref_q  <= 1'b0;
            pend_acc_q  <= 1'b0;
            ale_q       <= 1'b0;
            rreq_q      <= 1'b1;
            wst_q       <= 1'b0;
            row_lat_q   <= 8'h00;
            cs_lat_q    <= 1'b1;
            bank_lat_q  <= 1'b0;
            drive_req_q <= 1'b0;
            ref_shown_q <= 1'b0;
            echo_q      <= 6'h00;
        end else begin
            state_q     <= state_d;
            rate_q      <= rate_d;
            row_cnt_q   <= row_cnt_d;
            phase_q     <= phase_d;
            pend_ref_q  <= pend_ref_d;
            pend_acc_q  <= pend_acc_d;
            ale_q       <= ale_d;
            rreq_q      <= rreq_d;
            wst_q       <= wst_d;
            row_lat_q   <= row_lat_d;
            cs_lat_q    <= cs_lat_d;
            bank_lat_q  <= bank_lat_d;
            drive_req_q <= drive_req_d;
            ref_shown_q <= ref_shown_d;
            echo_q      <= echo_d;
        end
    end

    // ---------------------------------------------------------------
    // memory side outputs
    // ---------------------------------------------------------------
    // only one cycle type owns the pins; state is one-hot exclusive
    drac_mem_type mem_q, mem_d;

    always_comb begin
        mem_d = '{mem_addr_out: row_lat_q, mem_addr_oe_n: 1'b0,
                  row_strobe_bank0: 1'b1, row_strobe_bank1: 1'b1,
                  col_strobe: 1'b1, strobe_oe_n: 1'b0};
        if (ale) begin
            mem_d.mem_addr_out = rp4_q;
        end
        if (state_d == DRAC_REFRESH) begin
            mem_d.mem_addr_out     = row_cnt_d;
            mem_d.row_strobe_bank0 = 1'b0;
            mem_d.row_strobe_bank1 = 1'b0;
        end else if (state_d == DRAC_ACCESS || state_d == DRAC_HOLD) begin
            mem_d.row_strobe_bank0 = bank_lat_d;
            mem_d.row_strobe_bank1 = ~bank_lat_d;
            if (acc_on) begin
                mem_d.mem_addr_out = col_addr_in;
                mem_d.col_strobe   = 1'b0;
            end
            if (acc_float) begin
                mem_d.mem_addr_oe_n = 1'b1;
                mem_d.strobe_oe_n   = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_q <= '{mem_addr_out: 8'h00, mem_addr_oe_n: 1'b0,
                       row_strobe_bank0: 1'b1, row_strobe_bank1: 1'b1,
                       col_strobe: 1'b1, strobe_oe_n: 1'b0};
        end else begin
            mem_q <= mem_d;
        end
    end

    assign mem = mem_q;

    // ---------------------------------------------------------------
    // cpu side handshakes
    // ---------------------------------------------------------------
    // open-drain: oe_n low pulls the line low until refresh is shown
    assign refresh_req_out  = 1'b0;
    assign refresh_req_oe_n = ~(drive_req_q & ~ref_shown_q);

    // ready drops while an access waits behind refresh or a wait state
    // no wait state with the strap low; one with it high
    assign ready = ~((pend_acc_q && !cs_lat_q &&
                      (pend_ref_q || state_q == DRAC_REFRESH)) ||
                     (state_q == DRAC_ACCESS && wst &&
                      phase_q == 3'd0));

endmodule : drac_ctrl
`default_nettype wire

/* bench/drac_partner.sv */
// drac bench: processor bus and open-drain refresh line model
`default_nettype none
module drac_partner (
    input  wire logic       sys_clk,
    input  wire logic       ale,
    input  wire logic [7:0] cpu_row,
    input  wire logic       ext_pull,
    input  wire logic       dev_oe_n,
    output logic [7:0]      row_bus,
    output logic            line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic held_q;
    // data phase replaces the address one clock after the strobe falls
    always_ff @(posedge sys_clk) held_q <= ale;
    assign row_bus = (ale || held_q) ? cpu_row : ~cpu_row;
    // pull-up wins only when nobody pulls low
    assign line = !(ext_pull || !dev_oe_n);
endmodule : drac_partner
`default_nettype wire

/* bench/drac_ctrl_assertions.sv */
// drac bench: port assertions for the controller
`default_nettype none
module drac_ctrl_assertions (
    input wire logic                     sys_clk,
    input wire logic                     reset_n,
    input wire drac_pkg::drac_strap_type straps,
    input wire logic                     addr_latch_strobe,
    input wire logic                     bank_select_in,
    input wire logic [7:0]               row_addr_in,
    input wire logic                     read_access_ctl_n,
    input wire logic                     write_access_ctl_n,
    input wire logic                     refresh_req_in,
    input wire logic                     refresh_req_oe_n,
    input wire drac_pkg::drac_mem_type   mem,
    input wire logic                     ready
);
    import drac_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic b0, b1, both, short_sel, ale_q, bank_q, bank_d;
    assign b0 = !mem.row_strobe_bank0 && !mem.strobe_oe_n;
    assign b1 = !mem.row_strobe_bank1 && !mem.strobe_oe_n;
    assign both = b0 && b1;
    assign short_sel = straps inside {3'b001, 3'b010, 3'b100};
    // bank as the bus held it at the strobe fall
    always_comb bank_d = (ale_q && !addr_latch_strobe) ? bank_select_in
                                                        : bank_q;
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) {ale_q, bank_q} <= 2'b00;
        else {ale_q, bank_q} <= {addr_latch_strobe, bank_d};
    a_no_overlap:
    assert property (both |-> mem.col_strobe) else $error("cycle overlap");
    a_bank_pick:
    assert property ((b0 != b1) |-> b1 == bank_q) else $error("wrong bank");
    a_float_both:
    assert property ((!read_access_ctl_n && !write_access_ctl_n)[*7]
        |-> mem.mem_addr_oe_n && mem.strobe_oe_n) else $error("no float");
    a_short_ref:
    assert property ($rose(both) && short_sel |-> both[*3] ##1 !both)
        else $error("short refresh length");
    a_long_ref:
    assert property ($rose(both) && !short_sel |-> both[*4] ##1 !both)
        else $error("long refresh length");
    a_timer_off:
    assert property ((straps == 3'b000 && refresh_req_in)[*8] |-> !both)
        else $error("refresh with timer held");
    a_req_start:
    assert property ($fell(refresh_req_oe_n) |-> ##[0:4] both)
        else $error("request without refresh");
    a_req_hold:
    assert property ($rose(refresh_req_oe_n) |-> both)
        else $error("request released early");
    a_ready_back:
    assert property ($fell(ready) |-> ##[1:12] ready)
        else $error("ready stuck low");
    a_row_pass:
    assert property ((addr_latch_strobe && read_access_ctl_n
        && write_access_ctl_n && refresh_req_oe_n && !both
        && $stable(row_addr_in))[*6] |-> mem.mem_addr_out == row_addr_in)
        else $error("row not passed");
endmodule : drac_ctrl_assertions
bind drac_ctrl drac_ctrl_assertions drac_ctrl_assertions_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .straps(straps),
    .addr_latch_strobe(addr_latch_strobe), .bank_select_in(bank_select_in),
    .row_addr_in(row_addr_in), .read_access_ctl_n(read_access_ctl_n),
    .write_access_ctl_n(write_access_ctl_n),
    .refresh_req_in(refresh_req_in),
    .refresh_req_oe_n(refresh_req_oe_n), .mem(mem), .ready(ready));
`default_nettype wire

/* bench/tb_drac_ctrl.sv */
// drac bench: self-checking top level
`default_nettype none
module tb_drac_ctrl;
    import drac_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, reset_n = 0, ale = 0, cs_n = 1, bank = 0;
    logic rd_n = 1, wr_n = 1, pull = 0, line, oe_n, ready;
    logic [7:0] cpu_row = 8'h00, col = 8'h00, row_bus;
    drac_strap_type straps = 3'b000;
    drac_mem_type mem;
    int fails = 0, checks = 0;
    wire logic both = !mem.row_strobe_bank0 && !mem.row_strobe_bank1;
    always #4 sys_clk = ~sys_clk;
    drac_ctrl drac_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .straps(straps), .addr_latch_strobe(ale), .chip_select_n(cs_n),
        .bank_select_in(bank), .row_addr_in(row_bus), .col_addr_in(col),
        .read_access_ctl_n(rd_n), .write_access_ctl_n(wr_n),
        .refresh_req_in(line), .refresh_req_out(),
        .refresh_req_oe_n(oe_n), .mem(mem), .ready(ready));
    drac_partner drac_partner_i (.sys_clk(sys_clk), .ale(ale),
        .cpu_row(cpu_row), .ext_pull(pull), .dev_oe_n(oe_n),
        .row_bus(row_bus), .line(line));
    task check(input string what, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task wait_ref(output int n);
        n = 0;
        do begin @(negedge sys_clk); n++; end while (!both && n < 200);
        check("refresh seen", 8'(n < 200), 8'h01);
    endtask : wait_ref
    task len_ref(output int k);
        k = 0;
        while (both && k < 20) begin k++; @(negedge sys_clk); end
    endtask : len_ref
    task t_rate;
        int per[8] = '{0, 31, 46, 61, 46, 61, 76, 91};
        int n, k;
        for (int c = 1; c < 8; c++) begin
            @(posedge sys_clk) straps <= 3'b000;
            repeat (8) @(posedge sys_clk);
            straps <= 3'(c);
            wait_ref(n);
            if (c[2]) check("reload row", mem.mem_addr_out, 8'hFF);
            len_ref(k);
            check("ref len", 8'(k), (c < 3 || c == 4) ? 8'h03 : 8'h04);
            wait_ref(n);
            check("period", 8'(n + k), 8'(per[c]));
            if (c[2]) check("next row", mem.mem_addr_out, 8'hFE);
        end
        $display("test rate done");
    endtask : t_rate
    task t_ext;
        int n, k;
        @(posedge sys_clk) straps <= 3'b000;
        repeat (150) @(negedge sys_clk);
        check("timer held", 8'(both), 8'h00);
        @(posedge sys_clk) pull <= 1;
        wait_ref(n);
        check("line held", 8'(line), 8'h00);
        len_ref(k);
        check("ext len", 8'(k), 8'h04);
        @(posedge sys_clk) pull <= 0;
        $display("test external done");
    endtask : t_ext
    task t_access(input logic b, w);
        int n, lows;
        lows = 0;
        @(posedge sys_clk) straps <= {w, 2'b00};
        if (w) begin wait_ref(n); len_ref(n); end
        @(posedge sys_clk) {ale, cs_n, bank, cpu_row, col} <=
            {2'b10, b, 16'h5A_C3};
        repeat (8) @(negedge sys_clk);
        check("row pass", mem.mem_addr_out, 8'h5A);
        @(posedge sys_clk) ale <= 0;
        n = 0;
        do begin @(negedge sys_clk); n++; lows += !ready; end
        while (mem.row_strobe_bank0 && mem.row_strobe_bank1 && n < 20);
        check("bank", {mem.row_strobe_bank1, mem.row_strobe_bank0}, b ? 8'h01 : 8'h02);
        check("row held", mem.mem_addr_out, 8'h5A);
        @(posedge sys_clk) rd_n <= 0;
        n = 0;
        do begin @(negedge sys_clk); n++; lows += !ready; end
        while (mem.col_strobe && n < 8);
        check("col", mem.mem_addr_out, 8'hC3);
        repeat (10) begin @(negedge sys_clk); lows += !ready; end
        check("wait states", 8'(lows), 8'(w));
        @(posedge sys_clk) {ale, rd_n, wr_n, cs_n} <= 4'b1001;
        repeat (6) @(negedge sys_clk);
        check("float", {mem.mem_addr_oe_n, mem.strobe_oe_n}, 8'h03);
        @(posedge sys_clk) {rd_n, wr_n} <= 2'b11;
        repeat (6) @(negedge sys_clk);
        check("ended", {mem.row_strobe_bank1, mem.row_strobe_bank0}, 8'h03);
        $display("test access done");
    endtask : t_access
    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1;
        repeat (6) @(posedge sys_clk);
        t_rate();
        t_ext();
        t_access(0, 0);
        t_access(1, 1);
        give_verdict();
    end
    initial begin
        #(8 * 20000);
        fails++;
        give_verdict();
    end
endmodule : tb_drac_ctrl
`default_nettype wire
